// *** shared/pth_consts.svh ***
// constants for the processor bus tenure handshake master
`ifndef PTH_CONSTS_SVH
`define PTH_CONSTS_SVH
`define PTH_ADDR_W 32
`define PTH_HALF_W 32
`define PTH_DATA_W 64
`define PTH_LANES 8
`define PTH_LANE_W 8
`define PTH_ASSERTED 1'b0
`define PTH_NEGATED 1'b1
`define PTH_ZERO_ADDR 32'h0000_0000
`define PTH_ZERO_DATA 64'h0000_0000_0000_0000
`endif

// *** shared/pth_pkg.sv ***
// types for the processor bus tenure handshake master
package pth_pkg;
    typedef enum logic [4:0] {
        PTH_IDLE  = 5'h01,
        PTH_ADDR  = 5'h02,
        PTH_ARCHK = 5'h04,
        PTH_DWAIT = 5'h08,
        PTH_DATA  = 5'h10
    } pth_state_type;
endpackage : pth_pkg

// *** logic/pth_master.sv ***
// processor-side bus master for address and data tenure handshakes
`timescale 1ns/1ns
`include "pth_consts.svh"
module pth_master #(
    parameter int ADDR_W = `PTH_ADDR_W
) (
    // clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic RESETN_IN,
    // user request side
    input wire logic REQ_VALID_IN,
    input wire logic REQ_BURST_IN,
    input wire logic REQ_WRITE_IN,
    input wire logic [ADDR_W-1:0] REQ_ADDR_IN,
    input wire logic [`PTH_DATA_W-1:0] REQ_WDATA_IN,
    input wire logic SNOOP_RETRY_IN,
    output logic REQ_READY_OUT,
    output logic DONE_OUT,
    output logic RETRIED_OUT,
    output logic [`PTH_DATA_W-1:0] RDATA_OUT,
    // address tenure pins
    input wire logic ADDRESS_BUS_GRANT_N_IN,
    input wire logic TRANSFER_START_N_IN,
    output logic TRANSFER_START_N_OUT,
    output logic TRANSFER_START_OE_OUT,
    output logic [ADDR_W-1:0] ADDRESS_LINES_OUT,
    output logic ADDRESS_LINES_OE_OUT,
    output logic BURST_INDICATOR_N_OUT,
    output logic BURST_INDICATOR_OE_OUT,
    input wire logic ADDRESS_TENURE_ACK_N_IN,
    input wire logic ADDRESS_RETRY_N_IN,
    output logic ADDRESS_RETRY_N_OUT,
    output logic ADDRESS_RETRY_OE_OUT,
    // data tenure pins
    input wire logic DATA_BUS_GRANT_CPU_N_IN,
    input wire logic DATA_BUS_BUSY_N_IN,
    output logic DATA_BUS_BUSY_N_OUT,
    output logic DATA_BUS_BUSY_OE_OUT,
    input wire logic [`PTH_HALF_W-1:0] DATA_HIGH_HALF_IN,
    output logic [`PTH_HALF_W-1:0] DATA_HIGH_HALF_OUT,
    output logic DATA_HIGH_HALF_OE_OUT,
    input wire logic [`PTH_HALF_W-1:0] DATA_LOW_HALF_IN,
    output logic [`PTH_HALF_W-1:0] DATA_LOW_HALF_OUT,
    output logic DATA_LOW_HALF_OE_OUT
);

    pth_pkg::pth_state_type state_r;
    logic [5:0] meta_r;
    logic [5:0] sync_r;
    logic [`PTH_DATA_W-1:0] din_meta_r;
    logic [`PTH_DATA_W-1:0] din_sync_r;
    logic bg_s, ts_s, address_tenure_ack_s, address_retry_s, dbg_s, dbb_s;
    logic bg_seen_r, ts_first_r, burst_r, write_r, snoop_r, address_retry_drv_r;
    logic [ADDR_W-1:0] addr_r;
    logic [`PTH_DATA_W-1:0] wdata_r;
    logic [`PTH_DATA_W-1:0] lanes_out;
    logic [`PTH_DATA_W-1:0] lanes_in;
    logic own_addr, qual_grant;

    // pins pass two flops; the bus sees all handshakes one sync late
    always_ff @(posedge CORE_CLK_IN) begin
        meta_r <= {ADDRESS_BUS_GRANT_N_IN, TRANSFER_START_N_IN,
                   ADDRESS_TENURE_ACK_N_IN, ADDRESS_RETRY_N_IN,
                   DATA_BUS_GRANT_CPU_N_IN, DATA_BUS_BUSY_N_IN};
        sync_r <= meta_r;
        din_meta_r <= {DATA_LOW_HALF_IN, DATA_HIGH_HALF_IN};
        din_sync_r <= din_meta_r;
    end

    // active-low pins turned into active-high internal levels
    assign bg_s = (sync_r[5] == `PTH_ASSERTED);
    assign ts_s = (sync_r[4] == `PTH_ASSERTED);
    assign address_tenure_ack_s = (sync_r[3] == `PTH_ASSERTED);
    assign address_retry_s = (sync_r[2] == `PTH_ASSERTED);
    assign dbg_s = (sync_r[1] == `PTH_ASSERTED);
    assign dbb_s = (sync_r[0] == `PTH_ASSERTED);

    assign own_addr = (state_r == pth_pkg::PTH_ADDR);
    // any retry seen blocks the data grant, whether for our own address tenure or a pipelined one
    assign qual_grant = dbg_s && !dbb_s && !address_retry_s;

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RESETN_IN) begin
            bg_seen_r <= 1'b0;
        end else begin
            bg_seen_r <= bg_s;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RESETN_IN) begin
            state_r <= pth_pkg::PTH_IDLE;
            ts_first_r <= 1'b0;
            DONE_OUT <= 1'b0;
            RETRIED_OUT <= 1'b0;
        end else begin
            DONE_OUT <= 1'b0;
            RETRIED_OUT <= 1'b0;
            ts_first_r <= 1'b0;
            case (state_r)
                pth_pkg::PTH_IDLE: begin
                    if (REQ_VALID_IN && bg_seen_r && bg_s) begin
                        state_r <= pth_pkg::PTH_ADDR;
                        ts_first_r <= 1'b1;
                    end
                end
                pth_pkg::PTH_ADDR: begin
                    // tenure stays open until the ack is seen
                    if (address_tenure_ack_s && !ts_first_r) begin
                        state_r <= pth_pkg::PTH_ARCHK;
                    end
                end
                pth_pkg::PTH_ARCHK: begin
                    if (address_retry_s) begin
                        state_r <= pth_pkg::PTH_IDLE;
                        RETRIED_OUT <= 1'b1;
                    end else begin
                        state_r <= pth_pkg::PTH_DWAIT;
                    end
                end
                pth_pkg::PTH_DWAIT: begin
                    if (qual_grant) begin
                        state_r <= pth_pkg::PTH_DATA;
                    end
                end
                pth_pkg::PTH_DATA: begin
                    state_r <= pth_pkg::PTH_IDLE;
                    DONE_OUT <= 1'b1;
                end
                default: begin
                    state_r <= pth_pkg::PTH_IDLE;
                end
            endcase
        end
    end

    // request latched once so address stays stable for the whole tenure
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RESETN_IN) begin
            addr_r <= ADDR_W'(`PTH_ZERO_ADDR);
            wdata_r <= `PTH_ZERO_DATA;
            burst_r <= 1'b0;
            write_r <= 1'b0;
        end else if (state_r == pth_pkg::PTH_IDLE && REQ_VALID_IN
                     && bg_seen_r && bg_s) begin
            addr_r <= REQ_ADDR_IN;
            wdata_r <= REQ_WDATA_IN;
            burst_r <= REQ_BURST_IN;
            write_r <= REQ_WRITE_IN;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RESETN_IN) begin
            RDATA_OUT <= `PTH_ZERO_DATA;
        end else if (state_r == pth_pkg::PTH_DATA && !write_r) begin
            RDATA_OUT <= lanes_in;
        end
    end

    // snooper: retry another master's tenure on request, one clock wide
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RESETN_IN) begin
            snoop_r <= 1'b0;
            address_retry_drv_r <= 1'b0;
        end else begin
            address_retry_drv_r <= snoop_r && address_tenure_ack_s && SNOOP_RETRY_IN;
            // a start seen with the old ack opens the next snoop, so set wins
            if (ts_s && state_r == pth_pkg::PTH_IDLE) begin
                snoop_r <= 1'b1;
            end else if (address_tenure_ack_s) begin
                snoop_r <= 1'b0;
            end
        end
    end

    // byte lane k sits at bits 8k+7:8k on both sides
    genvar g;
    generate
        for (g = 0; g < `PTH_LANES; g++) begin : g_lane
            assign lanes_out[g*`PTH_LANE_W +: `PTH_LANE_W] =
                wdata_r[g*`PTH_LANE_W +: `PTH_LANE_W];
            assign lanes_in[g*`PTH_LANE_W +: `PTH_LANE_W] =
                din_sync_r[g*`PTH_LANE_W +: `PTH_LANE_W];
        end
    endgenerate

    assign REQ_READY_OUT = (state_r == pth_pkg::PTH_IDLE) && bg_seen_r && bg_s;
    assign TRANSFER_START_N_OUT = ts_first_r ? `PTH_ASSERTED : `PTH_NEGATED;
    assign TRANSFER_START_OE_OUT = own_addr;
    assign ADDRESS_LINES_OUT = addr_r;
    assign ADDRESS_LINES_OE_OUT = own_addr;
    assign BURST_INDICATOR_N_OUT = burst_r ? `PTH_ASSERTED : `PTH_NEGATED;
    assign BURST_INDICATOR_OE_OUT = own_addr;
    assign ADDRESS_RETRY_N_OUT = `PTH_ASSERTED;
    assign ADDRESS_RETRY_OE_OUT = address_retry_drv_r;
    assign DATA_BUS_BUSY_N_OUT = `PTH_ASSERTED;
    assign DATA_BUS_BUSY_OE_OUT = (state_r == pth_pkg::PTH_DATA);
    assign DATA_HIGH_HALF_OUT = lanes_out[`PTH_HALF_W-1:0];
    assign DATA_LOW_HALF_OUT = lanes_out[`PTH_DATA_W-1:`PTH_HALF_W];
    assign DATA_HIGH_HALF_OE_OUT = (state_r == pth_pkg::PTH_DATA) && write_r;
    assign DATA_LOW_HALF_OE_OUT = (state_r == pth_pkg::PTH_DATA) && write_r;

    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RESETN_IN);

    a_ts_one_cycle: assert property (
        !TRANSFER_START_N_OUT |=> TRANSFER_START_N_OUT && ADDRESS_LINES_OE_OUT)
        else $error("transfer start longer than one cycle");
    a_ts_after_grant: assert property (
        $fell(TRANSFER_START_N_OUT) |-> $past(bg_s, 2) && $past(bg_s))
        else $error("transfer start without prior grant");
    a_addr_stable: assert property (
        ADDRESS_LINES_OE_OUT && !address_tenure_ack_s |=> ADDRESS_LINES_OE_OUT
            && $stable(ADDRESS_LINES_OUT) && $stable(BURST_INDICATOR_N_OUT))
        else $error("address tenure dropped before ack");
    a_float_after_ack: assert property (
        own_addr && address_tenure_ack_s && !ts_first_r |=> !ADDRESS_LINES_OE_OUT
            && !BURST_INDICATOR_OE_OUT && !TRANSFER_START_OE_OUT)
        else $error("address signals not floated after ack");
    a_retry_honoured: assert property (
        state_r == pth_pkg::PTH_ARCHK && address_retry_s |=> RETRIED_OUT
            && state_r == pth_pkg::PTH_IDLE && !DATA_BUS_BUSY_OE_OUT)
        else $error("retry not honoured");
    a_qual_grant: assert property (
        $rose(DATA_BUS_BUSY_OE_OUT) |-> $past(dbg_s) && !$past(dbb_s)
            && !$past(address_retry_s))
        else $error("data bus taken without qualified grant");
    a_burst_level: assert property (
        $rose(BURST_INDICATOR_OE_OUT) |->
            (BURST_INDICATOR_N_OUT == !$past(REQ_BURST_IN)))
        else $error("burst indicator level wrong");
    a_retry_pulse: assert property (
        ADDRESS_RETRY_OE_OUT |-> $past(address_tenure_ack_s) && $past(snoop_r)
            ##1 !ADDRESS_RETRY_OE_OUT)
        else $error("retry drive not a single cycle after ack");
    a_data_done: assert property (
        DATA_BUS_BUSY_OE_OUT |=> DONE_OUT && !DATA_BUS_BUSY_OE_OUT)
        else $error("data tenure not closed in one cycle");

    c_plain_write: cover property (
        own_addr && !burst_r && write_r ##[1:20] DONE_OUT);
    c_burst_read: cover property (
        own_addr && burst_r && !write_r ##[1:20] DONE_OUT);
    c_retried: cover property (own_addr ##[1:20] RETRIED_OUT);
    c_snoop_retry: cover property (ADDRESS_RETRY_OE_OUT);

endmodule : pth_master

// *** verif/pth_bridge_model.sv ***
// bridge-side partner: grants, acks, retries, snoops, read data
`timescale 1ns/1ns
module pth_bridge_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // bench control
    input wire logic [2:0] ack_dly_in,
    input wire logic retry_req_in,
    input wire logic snoop_go_in,
    input wire logic [63:0] rdata_in,
    // bus wires
    input wire logic ts_n_in,
    input wire logic busy_n_in,
    input wire logic retry_n_in,
    output logic grant_n_out,
    output logic ts_n_out,
    output logic ts_oe_out,
    output logic burst_n_out,
    output logic ack_n_out,
    output logic retry_n_out,
    output logic dbg_n_out,
    output logic snp_retry_out,
    output logic snp_done_out,
    output logic [63:0] data_out
);
    logic [2:0] st_r;
    logic snp_r;
    logic hit_r;
    int cnt_r;
    always_ff @(posedge clk_in) begin
        ts_n_out <= 1'b1;
        ack_n_out <= 1'b1;
        retry_n_out <= 1'b1;
        dbg_n_out <= 1'b1;
        snp_done_out <= 1'b0;
        if (!rstn_in) begin
            st_r <= 3'h0;
            ts_oe_out <= 1'b0;
            grant_n_out <= 1'b1;
            burst_n_out <= 1'b1;
            snp_retry_out <= 1'b0;
            data_out <= 64'h0;
        end else case (st_r)
            3'h0: begin
                grant_n_out <= 1'b0;
                snp_r <= snoop_go_in;
                if (snoop_go_in) begin
                    grant_n_out <= 1'b1;
                    ts_n_out <= 1'b0;
                    ts_oe_out <= 1'b1;
                    burst_n_out <= 1'b0;
                    cnt_r <= int'(ack_dly_in);
                    st_r <= 3'h1;
                end else if (!ts_n_in) begin
                    cnt_r <= int'(ack_dly_in) - 1;
                    st_r <= 3'h1;
                end
            end
            3'h1: begin
                if (cnt_r <= 1) begin
                    ack_n_out <= 1'b0;
                    st_r <= 3'h2;
                end
                cnt_r <= cnt_r - 1;
            end
            3'h2: begin
                ts_oe_out <= 1'b0;
                retry_n_out <= snp_r | !retry_req_in;
                hit_r <= 1'b0;
                cnt_r <= 4;
                st_r <= 3'h3;
            end
            3'h3: begin
                // master inputs lag by synchronisers, so the slot is widened
                if (!retry_n_in) hit_r <= 1'b1;
                cnt_r <= cnt_r - 1;
                if (cnt_r == 1) begin
                    st_r <= (snp_r | hit_r | !retry_n_in) ? 3'h0 : 3'h4;
                    snp_done_out <= snp_r;
                    snp_retry_out <= hit_r | !retry_n_in;
                    dbg_n_out <= snp_r | hit_r | !retry_n_in;
                    data_out <= rdata_in;
                end
            end
            3'h4: begin
                cnt_r <= 4;
                if (!busy_n_in) st_r <= 3'h5;
            end
            default: begin
                cnt_r <= cnt_r - 1;
                if (cnt_r == 0) begin
                    data_out <= ~data_out; // released lines must not hold
                    st_r <= 3'h0;
                end
            end
        endcase
    end
endmodule : pth_bridge_model

// *** verif/processor_bus_tenure_handshake_tb.sv ***
// self-checking bench for the tenure handshake master
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    n_errors++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module processor_bus_tenure_handshake_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic req_valid = 1'b0, req_burst = 1'b0, req_write = 1'b0;
    logic snoop_retry = 1'b0, retry_req = 1'b0, snoop_go = 1'b0;
    logic [31:0] req_addr = 32'h0;
    logic [63:0] req_wdata = 64'h0;
    logic [2:0] ack_dly = 3'h2;
    int n_errors = 0;
    int total_checks = 0;
    int k;
    wire logic rdy, done, retried, ts_o, ts_oe, addr_oe, bst_o, bst_oe;
    wire logic r_o, r_oe, bsy_o, bsy_oe, dh_oe, dl_oe, gnt, ack, dbg;
    wire logic m_ts, m_ts_oe, m_r, s_ret, s_done;
    wire logic [31:0] addr_o, dh_o, dl_o;
    wire logic [63:0] rdata, m_data;
    wire logic ts_w = ts_oe ? ts_o : (m_ts_oe ? m_ts : 1'b1);
    wire logic retry_w = !((r_oe && !r_o) || !m_r);
    wire logic busy_w = !(bsy_oe && !bsy_o);
    wire logic [31:0] dh_w = dh_oe ? dh_o : m_data[31:0];
    wire logic [31:0] dl_w = dl_oe ? dl_o : m_data[63:32];
    always #5 clk = ~clk;
    function automatic logic [63:0] exp_rd(input logic [31:0] a);
        return {~a, a ^ 32'h5A5A_A5A5};
    endfunction : exp_rd
    pth_master DUT (
        .CORE_CLK_IN(clk), .RESETN_IN(rstn),
        .REQ_VALID_IN(req_valid), .REQ_BURST_IN(req_burst),
        .REQ_WRITE_IN(req_write), .REQ_ADDR_IN(req_addr),
        .REQ_WDATA_IN(req_wdata), .SNOOP_RETRY_IN(snoop_retry),
        .REQ_READY_OUT(rdy), .DONE_OUT(done), .RETRIED_OUT(retried),
        .RDATA_OUT(rdata), .ADDRESS_BUS_GRANT_N_IN(gnt),
        .TRANSFER_START_N_IN(ts_w), .TRANSFER_START_N_OUT(ts_o),
        .TRANSFER_START_OE_OUT(ts_oe), .ADDRESS_LINES_OUT(addr_o),
        .ADDRESS_LINES_OE_OUT(addr_oe), .BURST_INDICATOR_N_OUT(bst_o),
        .BURST_INDICATOR_OE_OUT(bst_oe), .ADDRESS_TENURE_ACK_N_IN(ack),
        .ADDRESS_RETRY_N_IN(retry_w), .ADDRESS_RETRY_N_OUT(r_o),
        .ADDRESS_RETRY_OE_OUT(r_oe), .DATA_BUS_GRANT_CPU_N_IN(dbg),
        .DATA_BUS_BUSY_N_IN(busy_w), .DATA_BUS_BUSY_N_OUT(bsy_o),
        .DATA_BUS_BUSY_OE_OUT(bsy_oe), .DATA_HIGH_HALF_IN(dh_w),
        .DATA_HIGH_HALF_OUT(dh_o), .DATA_HIGH_HALF_OE_OUT(dh_oe),
        .DATA_LOW_HALF_IN(dl_w), .DATA_LOW_HALF_OUT(dl_o),
        .DATA_LOW_HALF_OE_OUT(dl_oe));
    pth_bridge_model MDL (
        .clk_in(clk), .rstn_in(rstn), .ack_dly_in(ack_dly),
        .retry_req_in(retry_req), .snoop_go_in(snoop_go),
        .rdata_in(exp_rd(req_addr)), .ts_n_in(ts_w), .busy_n_in(busy_w),
        .retry_n_in(retry_w), .grant_n_out(gnt), .ts_n_out(m_ts),
        .ts_oe_out(m_ts_oe), .burst_n_out(), .ack_n_out(ack),
        .retry_n_out(m_r), .dbg_n_out(dbg), .snp_retry_out(s_ret),
        .snp_done_out(s_done), .data_out(m_data));
    task final_report;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    task xfer(input logic b, w, rt, input logic [31:0] a,
              input logic [63:0] d, input logic [2:0] dl);
        int i;
        logic seen;
        logic bseen;
        seen = 1'b0;
        bseen = 1'b0;
        @(negedge clk);
        req_valid = 1'b1;
        req_burst = b;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        retry_req = rt;
        ack_dly = dl;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (rdy === 1'b1) break;
        end
        @(negedge clk);
        req_valid = 1'b0;
        for (i = 0; i < 60; i++) begin
            @(posedge clk);
            if (ts_oe === 1'b1 && ts_o === 1'b0) begin
                `CHK("addr", a, addr_o)
                `CHK("burst", !b, bst_o)
                `CHK("addr_oe", 1'b1, addr_oe && bst_oe)
            end
            if (dh_oe === 1'b1) begin
                seen = 1'b1;
                `CHK("wdata", d, {dl_o, dh_o})
            end
            if (bsy_oe === 1'b1) begin
                bseen = 1'b1;
                `CHK("busy_n", 1'b0, bsy_o)
                `CHK("dl_oe", w, dl_oe)
            end
            if (done === 1'b1 || retried === 1'b1) break;
        end
        `CHK("retried", rt, retried)
        `CHK("done", !rt, done)
        if (!rt && !w) `CHK("rdata", exp_rd(a), rdata)
        `CHK("data_tenure", w && !rt, seen)
        `CHK("busy_tenure", !rt, bseen)
        repeat (12) @(posedge clk);
    endtask : xfer
    task snoop(input logic s);
        int i;
        int nr;
        nr = 0;
        @(negedge clk);
        snoop_retry = s;
        snoop_go = 1'b1;
        @(negedge clk);
        snoop_go = 1'b0;
        for (i = 0; i < 30; i++) begin
            @(posedge clk);
            if (r_oe === 1'b1) begin
                nr++;
                `CHK("retry_n", 1'b0, r_o)
            end
            if (s_done === 1'b1) break;
        end
        `CHK("snoop_retry", s, s_ret)
        `CHK("retry_pulses", int'(s), nr)
        snoop_retry = 1'b0;
        repeat (8) @(posedge clk);
    endtask : snoop
    // a hang would otherwise run forever; the tests need far less
    initial begin
        #200000;
        n_errors++;
        final_report;
    end
    initial begin
        void'($urandom(68942));
        repeat (10) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(posedge clk);
        xfer(1'b1, 1'b0, 1'b1, 32'h0000_0100, 64'h0, 3'h2);
        xfer(1'b1, 1'b1, 1'b0, 32'hFFFF_FFF8, 64'h0123_4567_89AB_CDEF, 3'h5);
        snoop(1'b1);
        snoop(1'b0);
        for (k = 0; k < 16; k++) begin
            xfer(1'($urandom), 1'($urandom), ($urandom % 4) == 0,
                 $urandom, {$urandom, $urandom}, 3'h2 + 3'($urandom % 4));
        end
        final_report;
    end
endmodule : processor_bus_tenure_handshake_tb
